// *** tmc_timer_counter.v ***
// tmc_timer_counter.v: two 16-bit timer/counters with mode and control registers
// and the two external request flags sharing the control register.
// assumes a core driving a one-cycle special function register port and vector pulses.
//
// Behaviour
// - timer 1 gated: counts only while request b pin high and run bit set
// - timer 0 gated: counts only while request a pin high and run bit set
// - timer 1 select bit chooses count pin events or internal machine cycles
// - timer 0 select bit chooses count pin events or internal machine cycles
// - mode 00: high byte counts behind a 5-bit low byte prescaler
// - mode 01: low and high bytes cascade into one 16-bit counter
// - mode 10: low byte counts, reloads from high byte on overflow
// - timer 0 uses the same structure for modes 00, 01 and 10
// - timer 1 in mode 11 stops and holds its count
// - timer 0 mode 11: low byte is 8-bit counter under timer 0 controls
// - timer 0 mode 11: high byte counts machine cycles under timer 1 run bit
// - each overflow flag is set by hardware on its timer overflow, except in timer 0 mode 11 where TF1 is set by the timer 0 high byte
// - overflow flag cleared when the core vectors to its service routine
// - run bit written by software switches its timer on or off
// - external flag set on falling edge or low level per trigger bit
// - vectoring clears external flag only when edge triggered; level follows source
// - trigger bit set means 1-to-0 edge, clear means sustained low level
// - each timer holds its count in two 8-bit byte registers
// - timer function increments once per machine cycle of twelve clocks
// - counter function samples pin per machine cycle, counts high then low
// - mode 00 count is high byte plus low five bits of low byte
// - auto reload leaves the high byte unchanged
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.vh"

module tmc_timer_counter (
  input wire i_clk,
  input wire i_reset,
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire [7:0] i_sfr_wdata,
  input wire i_vec_first_timer,
  input wire i_vec_second_timer,
  input wire i_vec_ext_a,
  input wire i_vec_ext_b,
  input wire i_ext_request_a_pin,
  input wire i_ext_request_b_pin,
  input wire i_first_count_input_pin,
  input wire i_second_count_input_pin,
  output reg [7:0] o_sfr_rdata,
  output wire o_first_timer_overflow_flag,
  output wire o_second_timer_overflow_flag,
  output wire o_ext_request_a_flag,
  output wire o_ext_request_b_flag
);

  reg [7:0] timer_run_and_flag_control_q;
  reg [7:0] timer_run_and_flag_control_d;
  reg [7:0] timer_mode_select_q;
  reg [7:0] tl0_q;
  reg [7:0] th0_q;
  reg [7:0] tl1_q;
  reg [7:0] th1_q;
  reg [`TMC_MC_CNT_W-1:0] mc_cnt_q;
  reg mc_en_q;
  reg [1:0] samp_q;
  reg [1:0] ext_prev_q;
  reg [7:0] rdata_d;
  wire [3:0] pin_in;
  wire [3:0] lvl;
  wire [1:0] mode0;
  wire [1:0] mode1;
  wire split0;
  wire en0;
  wire en1;
  wire src0;
  wire src1;
  wire tick0;
  wire tick1;
  wire th0_run;
  wire [8:0] th0_inc;
  wire [16:0] st0;
  wire [16:0] st1;
  wire set_tf0;
  wire set_tf1;
  wire [1:0] ext_fall;
  wire wr_ctrl;
  wire wr_mode;
  wire wr_tl0;
  wire wr_th0;
  wire wr_tl1;
  wire wr_th1;
  wire mc_wrap;

  // one count step of a timer for the given mode: {overflow, high, low}
  function [16:0] tmc_step;
    input [1:0] mode;
    input [7:0] tl;
    input [7:0] th;
    reg [13:0] s13;
    reg [16:0] s16;
    reg [8:0] s8;
    begin
      s13 = {1'b0, th, tl[4:0]} + 14'h0001;
      s16 = {1'b0, th, tl} + 17'h00001;
      s8 = {1'b0, tl} + 9'h001;
      case (mode)
        `TMC_MODE_13BIT: tmc_step = {s13[13], s13[12:5], tl[7:5], s13[4:0]};
        `TMC_MODE_16BIT: tmc_step = s16;
        `TMC_MODE_RELOAD: tmc_step = {s8[8], th, s8[8] ? th : s8[7:0]};
        default: tmc_step = {s8[8], th, s8[7:0]};
      endcase
    end
  endfunction

  // write strobe decode for one register address
  function tmc_wr_hit;
    input wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      tmc_wr_hit = wr & (addr == target);
    end
  endfunction

  // three-stage pin synchronisers; level moves once stages two and three agree
  assign pin_in = {i_ext_request_b_pin, i_ext_request_a_pin,
                   i_second_count_input_pin, i_first_count_input_pin};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : pin_sync
      reg [2:0] sync_q;
      reg lvl_q;
      always @(posedge i_clk)
      begin
        if (i_reset)
        begin
          sync_q <= 3'h7;
          lvl_q <= 1'b1;
        end
        else
        begin
          sync_q <= {sync_q[1:0], pin_in[g]};
          if (sync_q[1] == sync_q[2])
            lvl_q <= sync_q[2];
        end
      end
      assign lvl[g] = lvl_q;
    end
  endgenerate

  assign mc_wrap = (mc_cnt_q == `TMC_MC_LAST);

  // machine cycle enable, one pulse every twelve clocks
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      mc_cnt_q <= {`TMC_MC_CNT_W{1'b0}};
      mc_en_q <= 1'b0;
    end
    else
    begin
      mc_en_q <= mc_wrap;
      if (mc_wrap)
        mc_cnt_q <= {`TMC_MC_CNT_W{1'b0}};
      else
        mc_cnt_q <= mc_cnt_q + 1'b1;
    end
  end

  // count pins sampled once per machine cycle; external pins tracked every clock
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      samp_q <= 2'h3;
      ext_prev_q <= 2'h3;
    end
    else
    begin
      if (mc_en_q)
        samp_q <= lvl[1:0];
      ext_prev_q <= lvl[3:2];
    end
  end

  assign ext_fall = ext_prev_q & ~lvl[3:2];

  assign mode0 = timer_mode_select_q[`TMC_M0_HI:`TMC_M0_LO];
  assign mode1 = timer_mode_select_q[`TMC_M1_HI:`TMC_M1_LO];
  assign split0 = (mode0 == `TMC_MODE_SPLIT);

  assign en0 = timer_run_and_flag_control_q[`TMC_TR0] & (~timer_mode_select_q[`TMC_GATE0] | lvl[2]);
  assign en1 = timer_run_and_flag_control_q[`TMC_TR1] & (~timer_mode_select_q[`TMC_GATE1] | lvl[3]);

  assign src0 = timer_mode_select_q[`TMC_CSEL0] ? (mc_en_q & samp_q[0] & ~lvl[0]) : mc_en_q;
  assign src1 = timer_mode_select_q[`TMC_CSEL1] ? (mc_en_q & samp_q[1] & ~lvl[1]) : mc_en_q;

  assign tick0 = en0 & src0;
  assign tick1 = en1 & src1 & (mode1 != `TMC_MODE_SPLIT);

  assign st0 = tmc_step(mode0, tl0_q, th0_q);
  assign st1 = tmc_step(mode1, tl1_q, th1_q);

  assign th0_run = split0 & timer_run_and_flag_control_q[`TMC_TR1] & mc_en_q;
  assign th0_inc = {1'b0, th0_q} + 9'h001;

  assign set_tf0 = tick0 & st0[16];
  assign set_tf1 = split0 ? (th0_run & th0_inc[8]) : (tick1 & st1[16]);

  // register write strobes
  assign wr_ctrl = tmc_wr_hit(i_sfr_wr, i_sfr_addr, `TMC_ADDR_CTRL);
  assign wr_mode = tmc_wr_hit(i_sfr_wr, i_sfr_addr, `TMC_ADDR_MODE);
  assign wr_tl0 = tmc_wr_hit(i_sfr_wr, i_sfr_addr, `TMC_ADDR_TL0);
  assign wr_th0 = tmc_wr_hit(i_sfr_wr, i_sfr_addr, `TMC_ADDR_TH0);
  assign wr_tl1 = tmc_wr_hit(i_sfr_wr, i_sfr_addr, `TMC_ADDR_TL1);
  assign wr_th1 = tmc_wr_hit(i_sfr_wr, i_sfr_addr, `TMC_ADDR_TH1);

  // control register next value; hardware set wins over any clear
  always @*
  begin
    timer_run_and_flag_control_d = wr_ctrl ? i_sfr_wdata : timer_run_and_flag_control_q;
    timer_run_and_flag_control_d[`TMC_TF0] = set_tf0 | (~i_vec_first_timer & timer_run_and_flag_control_d[`TMC_TF0]);
    timer_run_and_flag_control_d[`TMC_TF1] = set_tf1 | (~i_vec_second_timer & timer_run_and_flag_control_d[`TMC_TF1]);
    if (timer_run_and_flag_control_q[`TMC_IT0])
      timer_run_and_flag_control_d[`TMC_IE0] = ext_fall[0] | (~i_vec_ext_a & timer_run_and_flag_control_d[`TMC_IE0]);
    else
      timer_run_and_flag_control_d[`TMC_IE0] = ~lvl[2];
    if (timer_run_and_flag_control_q[`TMC_IT1])
      timer_run_and_flag_control_d[`TMC_IE1] = ext_fall[1] | (~i_vec_ext_b & timer_run_and_flag_control_d[`TMC_IE1]);
    else
      timer_run_and_flag_control_d[`TMC_IE1] = ~lvl[3];
  end

  // register file and counters; a software write to a byte wins over counting
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      timer_run_and_flag_control_q <= `TMC_CTRL_RESET;
      timer_mode_select_q <= `TMC_MODE_RESET;
      tl0_q <= `TMC_BYTE_RESET;
      th0_q <= `TMC_BYTE_RESET;
      tl1_q <= `TMC_BYTE_RESET;
      th1_q <= `TMC_BYTE_RESET;
    end
    else
    begin
      timer_run_and_flag_control_q <= timer_run_and_flag_control_d;
      if (wr_mode)
        timer_mode_select_q <= i_sfr_wdata;
      if (wr_tl0)
        tl0_q <= i_sfr_wdata;
      else if (tick0)
        tl0_q <= st0[7:0];
      if (wr_th0)
        th0_q <= i_sfr_wdata;
      else if (split0)
      begin
        if (th0_run)
          th0_q <= th0_inc[7:0];
      end
      else if (tick0)
        th0_q <= st0[15:8];
      if (wr_tl1)
        tl1_q <= i_sfr_wdata;
      else if (tick1)
        tl1_q <= st1[7:0];
      if (wr_th1)
        th1_q <= i_sfr_wdata;
      else if (tick1)
        th1_q <= st1[15:8];
    end
  end

  // registered read data, one cycle after the address is presented
  always @*
  begin
    case (i_sfr_addr)
      `TMC_ADDR_CTRL: rdata_d = timer_run_and_flag_control_q;
      `TMC_ADDR_MODE: rdata_d = timer_mode_select_q;
      `TMC_ADDR_TL0: rdata_d = tl0_q;
      `TMC_ADDR_TL1: rdata_d = tl1_q;
      `TMC_ADDR_TH0: rdata_d = th0_q;
      `TMC_ADDR_TH1: rdata_d = th1_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_reset)
      o_sfr_rdata <= 8'h00;
    else
      o_sfr_rdata <= rdata_d;
  end

  assign o_first_timer_overflow_flag = timer_run_and_flag_control_q[`TMC_TF0];
  assign o_second_timer_overflow_flag = timer_run_and_flag_control_q[`TMC_TF1];
  assign o_ext_request_a_flag = timer_run_and_flag_control_q[`TMC_IE0];
  assign o_ext_request_b_flag = timer_run_and_flag_control_q[`TMC_IE1];

endmodule

`default_nettype wire

// *** tmc_defines.vh ***
// tmc_defines.vh: register addresses, field positions, reset values and timing counts
// for the dual timer/counter block; included by tmc_timer_counter.v
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

// special function register addresses
`define TMC_ADDR_CTRL 8'h88
`define TMC_ADDR_MODE 8'h89
`define TMC_ADDR_TL0 8'h8A
`define TMC_ADDR_TL1 8'h8B
`define TMC_ADDR_TH0 8'h8C
`define TMC_ADDR_TH1 8'h8D

// reset values
`define TMC_CTRL_RESET 8'h00
`define TMC_MODE_RESET 8'h00
`define TMC_BYTE_RESET 8'h00

// timer_run_and_flag_control bit positions
`define TMC_TF1 7
`define TMC_TR1 6
`define TMC_TF0 5
`define TMC_TR0 4
`define TMC_IE1 3
`define TMC_IT1 2
`define TMC_IE0 1
`define TMC_IT0 0

// timer_mode_select field positions (timer 1 upper nibble, timer 0 lower)
`define TMC_GATE1 7
`define TMC_CSEL1 6
`define TMC_M1_HI 5
`define TMC_M1_LO 4
`define TMC_GATE0 3
`define TMC_CSEL0 2
`define TMC_M0_HI 1
`define TMC_M0_LO 0

// mode field encodings
`define TMC_MODE_13BIT 2'h0
`define TMC_MODE_16BIT 2'h1
`define TMC_MODE_RELOAD 2'h2
`define TMC_MODE_SPLIT 2'h3

// machine cycle in core clock periods
`define TMC_MC_CLKS 12
`define TMC_MC_CNT_W 4
`define TMC_MC_LAST 4'hB

`endif

// *** tmc_timer_counter_checker.sv ***
// tmc_timer_counter_checker.sv: port assertions for the timer/counter block
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_counter_checker (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_vec_first_timer,
  input wire logic i_vec_second_timer,
  input wire logic i_vec_ext_a,
  input wire logic i_vec_ext_b,
  input wire logic i_ext_request_a_pin,
  input wire logic i_ext_request_b_pin,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_first_timer_overflow_flag,
  input wire logic o_second_timer_overflow_flag,
  input wire logic o_ext_request_a_flag,
  input wire logic o_ext_request_b_flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [1:0] it_q;
  always @(posedge i_clk)
    if (i_reset)
      it_q <= 2'h0;
    else if (i_sfr_wr && i_sfr_addr == 8'h88)
      it_q <= {i_sfr_wdata[2], i_sfr_wdata[0]};
  vec_first_a: assert property (i_vec_first_timer |=> !o_first_timer_overflow_flag)
    else $error("first overflow flag kept after vector");
  vec_second_a: assert property (i_vec_second_timer |=> !o_second_timer_overflow_flag)
    else $error("second overflow flag kept after vector");
  edge_vec_a: assert property (it_q[0] && i_vec_ext_a |=> !o_ext_request_a_flag)
    else $error("edge request flag kept after vector");
  edge_vec_b_a: assert property (it_q[1] && i_vec_ext_b |=> !o_ext_request_b_flag)
    else $error("edge request b flag kept after vector");
  level_a_a: assert property ((!it_q[0] && !i_ext_request_a_pin) [*8] |-> o_ext_request_a_flag)
    else $error("level request a not flagged");
  level_b_a: assert property ((!it_q[1] && !i_ext_request_b_pin) [*8] |-> o_ext_request_b_flag)
    else $error("level request b not flagged");
  level_idle_a: assert property ((!it_q[0] && i_ext_request_a_pin) [*8] |-> !o_ext_request_a_flag)
    else $error("level request a flagged while pin high");
  mode_rw_a: assert property (i_sfr_wr && i_sfr_addr == 8'h89 ##1 i_sfr_addr == 8'h89 && !i_sfr_wr
    |=> o_sfr_rdata == $past(i_sfr_wdata, 2))
    else $error("mode register read back differs");
  unmapped_zero_a: assert property (i_sfr_addr == 8'h80 |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  flag_read_a: assert property (i_sfr_addr == 8'h88 |=> {o_sfr_rdata[7], o_sfr_rdata[5],
    o_sfr_rdata[3], o_sfr_rdata[1]} == $past({o_second_timer_overflow_flag,
    o_first_timer_overflow_flag, o_ext_request_b_flag, o_ext_request_a_flag}))
    else $error("control read differs from flags");
  cover property ($rose(o_first_timer_overflow_flag));
  cover property ($rose(o_second_timer_overflow_flag));
  cover property (it_q[0] && $fell(o_ext_request_a_flag));
endmodule
bind tmc_timer_counter tmc_timer_counter_checker chk_u (.*);
`default_nettype wire

// *** tmc_pin_model.sv ***
// tmc_pin_model.sv: external count and request pins
// assumes the bench sets the request levels
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_model (
  input wire logic i_clk,
  input wire logic i_req_a_low,
  input wire logic i_req_b_low,
  output logic o_req_a,
  output logic o_req_b,
  output var logic o_cnt0,
  output logic o_cnt1
);
  logic [4:0] div_q = 5'h00;
  initial o_cnt0 = 1'b1;
  assign o_req_a = ~i_req_a_low;
  assign o_req_b = ~i_req_b_low;
  assign o_cnt1 = o_cnt0;
  always @(posedge i_clk)
  begin
    div_q <= (div_q == 5'h17) ? 5'h00 : div_q + 5'h01;
    if (div_q == 5'h17)
      o_cnt0 <= ~o_cnt0;
  end
endmodule
`default_nettype wire

// *** tmc_tb.sv ***
// tmc_tb.sv: self-checking bench for the timer/counter block
// assumes the pin model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic wr = 1'b0;
  logic la = 1'b0;
  logic lb = 1'b0;
  logic [7:0] ad = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [3:0] vec = 4'h0;
  wire [7:0] rd;
  wire [3:0] fl;
  wire pa, pb, c0, c1;
  int errors = 0;
  int samples_checked = 0;
  initial forever #4 i_clk = ~i_clk;
  tmc_pin_model pm_u (.i_clk(i_clk), .i_req_a_low(la), .i_req_b_low(lb), .o_req_a(pa),
    .o_req_b(pb), .o_cnt0(c0), .o_cnt1(c1));
  tmc_timer_counter dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_sfr_addr(ad), .i_sfr_wr(wr),
    .i_sfr_wdata(wd), .i_vec_first_timer(vec[0]), .i_vec_second_timer(vec[1]),
    .i_vec_ext_a(vec[2]), .i_vec_ext_b(vec[3]), .i_ext_request_a_pin(pa),
    .i_ext_request_b_pin(pb), .i_first_count_input_pin(c0), .i_second_count_input_pin(c1),
    .o_sfr_rdata(rd), .o_first_timer_overflow_flag(fl[0]), .o_second_timer_overflow_flag(fl[1]),
    .o_ext_request_a_flag(fl[2]), .o_ext_request_b_flag(fl[3]));
  task automatic final_report;
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    ad <= a;
    wr <= 1'b1;
    wd <= d;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    ad <= a;
    @(posedge i_clk);
    #1 cmp("read data", e, rd);
  endtask
  task automatic pv(input logic [3:0] m);
    @(posedge i_clk);
    vec <= m;
    @(posedge i_clk);
    vec <= 4'h0;
    #1 cmp("cleared flags", 8'h00, {4'h0, fl & m});
  endtask
  task automatic wflag(input int k, input int lim);
    int n;
    for (n = 0; n < lim && fl[k] !== 1'b1; n++)
      @(posedge i_clk) #1;
    if (n == lim)
    begin
      errors++;
      final_report();
    end
  endtask
  task automatic ovf(input int t, input logic [7:0] md, th, tl, eth, etl);
    wreg(8'h89, md);
    wreg(8'(8'h8C + t), th);
    wreg(8'(8'h8A + t), tl);
    wreg(8'h88, t ? 8'h40 : 8'h10);
    wflag(t, 400);
    rreg(8'(8'h8C + t), eth);
    rreg(8'(8'h8A + t), etl);
    pv(t ? 4'h2 : 4'h1);
    wreg(8'h88, 8'h00);
  endtask
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    rreg(8'h88, 8'h00);
    rreg(8'h80, 8'h00);
    wreg(8'h89, 8'hA5);
    rreg(8'h89, 8'hA5);
    ovf(0, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00);
    ovf(0, 8'h00, 8'hFF, 8'h1F, 8'h00, 8'h00);
    ovf(0, 8'h02, 8'hF0, 8'hFE, 8'hF0, 8'hF0);
    ovf(1, 8'h10, 8'hFF, 8'hFF, 8'h00, 8'h00);
    ovf(1, 8'h20, 8'h33, 8'hFF, 8'h33, 8'h33);
    ovf(0, 8'h05, 8'hFF, 8'hFE, 8'h00, 8'h00);
    ovf(1, 8'h50, 8'hFF, 8'hFF, 8'h00, 8'h00);
    wreg(8'h89, 8'h03);
    wreg(8'h8C, 8'hFF);
    wreg(8'h8A, 8'hFF);
    wreg(8'h88, 8'h50);
    wflag(0, 40);
    wflag(1, 40);
    rreg(8'h8C, 8'h00);
    rreg(8'h8A, 8'h00);
    pv(4'h3);
    wreg(8'h88, 8'h40);
    wreg(8'h89, 8'h30);
    wreg(8'h8B, 8'hFF);
    repeat (40) @(posedge i_clk);
    rreg(8'h8B, 8'hFF);
    cmp("second flag", 8'h00, {7'h00, fl[1]});
    wreg(8'h89, 8'h09);
    wreg(8'h8A, 8'hFF);
    wreg(8'h8C, 8'hFF);
    la <= 1'b1;
    wreg(8'h88, 8'h10);
    repeat (40) @(posedge i_clk);
    #1 cmp("gated flags", 8'h04, {4'h0, fl});
    @(posedge i_clk);
    la <= 1'b0;
    wflag(0, 40);
    pv(4'h1);
    wreg(8'h88, 8'h01);
    la <= 1'b1;
    wflag(2, 10);
    pv(4'h4);
    lb <= 1'b1;
    wreg(8'h89, 8'h90);
    wreg(8'h8B, 8'hFF);
    wreg(8'h8D, 8'hFF);
    wreg(8'h88, 8'h41);
    repeat (40) @(posedge i_clk);
    #1 cmp("gated b flags", 8'h08, {4'h0, fl});
    @(posedge i_clk);
    lb <= 1'b0;
    wflag(1, 40);
    pv(4'h2);
    wreg(8'h88, 8'h05);
    lb <= 1'b1;
    wflag(3, 10);
    pv(4'h8);
    final_report();
  end
endmodule
`default_nettype wire
